// ==== rtl/adc_config_register_map.sv ====
// Function
// - decode chip config 0x00-0x02, index/commit 0x05 and 0xFF, functions 0x08-0x22.
// - written function values reach active registers only when 0x01 hits 0xFF.
// - clock register resets to 0x01; clearing and committing turns stabilizer off.
// - every reset, hard or soft, reloads all configuration defaults.
// - undefined bit positions are not stored and change nothing.
// - identity register 0x01 is read-only, fixed eight-bit code, writes ignored.
// - grade register 0x02 is read-only, variant code in bits 6 to 4.
// - serial port shifts msb first after power-up until bit order changes.
module adc_config_register_map (
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic I_SCLK,
  input wire logic I_CSB_N,
  input wire logic I_SDIO,
  output logic O_SDIO,
  output logic O_SDIO_OE,
  output logic O_LSB_FIRST,
  output logic [5:0] O_DEVICE_INDEX,
  output logic [2:0] O_POWER_MODE,
  output logic O_DCS_ENABLE,
  output logic [7:0] O_TEST_IO
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_func(input logic [12:0] a);
    is_func = (a >= adc_cfg_pkg::ADDR_FUNC_FIRST) && (a <= adc_cfg_pkg::ADDR_FUNC_LAST);
  endfunction

  // offset into the function arrays; only meaningful where is_func holds
  function automatic logic [4:0] func_index(input logic [12:0] a);
    logic [12:0] d;
    d = a - adc_cfg_pkg::ADDR_FUNC_FIRST;
    func_index = d[4:0];
  endfunction

  // default of each function register
  function automatic logic [7:0] func_default(input logic [12:0] a);
    if (a == adc_cfg_pkg::ADDR_CLOCK_COND)
      func_default = adc_cfg_pkg::RST_CLOCK_COND;
    else if (a == adc_cfg_pkg::ADDR_POWER_MODES)
      func_default = adc_cfg_pkg::RST_POWER_MODES;
    else
      func_default = adc_cfg_pkg::RST_FUNC_OTHER;
  endfunction

  // bits that hold a defined feature; the rest are never stored
  function automatic logic [7:0] func_mask(input logic [12:0] a);
    if (a == adc_cfg_pkg::ADDR_CLOCK_COND)
      func_mask = adc_cfg_pkg::MASK_CLOCK_COND;
    else if (a == adc_cfg_pkg::ADDR_POWER_MODES)
      func_mask = adc_cfg_pkg::MASK_POWER_MODES;
    else
      func_mask = adc_cfg_pkg::MASK_FUNC_OTHER;
  endfunction

  // ----------------------------------------------------------------
  // serial engine
  // ----------------------------------------------------------------
  logic [12:0] addr;
  logic wr_stb;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic lsb_first_ff;

  serial_port_engine u_port (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_sclk(I_SCLK),
    .i_csb_n(I_CSB_N),
    .i_sdio(I_SDIO),
    .i_lsb_first(lsb_first_ff),
    .i_rd_data(rd_data),
    .o_sdio(O_SDIO),
    .o_sdio_oe(O_SDIO_OE),
    .o_addr(addr),
    .o_wr_stb(wr_stb),
    .o_wr_data(wr_data)
  );

  // ----------------------------------------------------------------
  // held write address
  // ----------------------------------------------------------------
  // the engine steps its address on the same edge that raises the
  // write strobe, so writes decode the address of one clock earlier;
  // reads keep the live address, which is what the shifter wants
  logic [12:0] wr_addr_ff;
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
      wr_addr_ff <= 13'h_0000;
    else
      wr_addr_ff <= addr;
  end

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  logic wr_port;
  logic wr_index;
  logic wr_func;
  logic commit;
  logic soft_rst;
  logic cfg_rst;
  assign wr_port = wr_stb && wr_addr_ff == adc_cfg_pkg::ADDR_PORT_SETUP;
  assign wr_index = wr_stb && wr_addr_ff == adc_cfg_pkg::ADDR_DEVICE_INDEX;
  assign wr_func = wr_stb && is_func(wr_addr_ff);
  // only the commit value itself triggers the transfer; others are dropped
  assign commit = wr_stb && wr_addr_ff == adc_cfg_pkg::ADDR_SHADOW_COMMIT
    && wr_data == adc_cfg_pkg::COMMIT_VALUE;
  // either mirrored soft reset bit is honoured; the serial engine is left
  // alone so the frame that carried the reset still closes cleanly
  assign soft_rst = wr_port
    && (wr_data[adc_cfg_pkg::PS_SOFT_RST_HI] || wr_data[adc_cfg_pkg::PS_SOFT_RST_LO]);
  assign cfg_rst = I_RST | soft_rst;

  // ----------------------------------------------------------------
  // port setup: takes effect at once, no commit needed
  // ----------------------------------------------------------------
  // msb first out of any reset, so the host can always reach the device
  always_ff @(posedge I_SYS_CLK)
  begin
    if (cfg_rst)
      lsb_first_ff <= 1'b0;
    else if (wr_port)
      lsb_first_ff <= wr_data[adc_cfg_pkg::PS_LSB_FIRST_HI]
        | wr_data[adc_cfg_pkg::PS_LSB_FIRST_LO];
  end

  // ----------------------------------------------------------------
  // device index: immediate, drives O_DEVICE_INDEX; later writes are not gated by it
  // ----------------------------------------------------------------
  logic [5:0] index_ff;
  always_ff @(posedge I_SYS_CLK)
  begin
    if (cfg_rst)
      index_ff <= adc_cfg_pkg::RST_DEVICE_INDEX[5:0];
    else if (wr_index)
      index_ff <= wr_data[5:0];
  end

  // ----------------------------------------------------------------
  // function registers: shadow and active copies
  // ----------------------------------------------------------------
  logic [7:0] shadow_ff [adc_cfg_pkg::FUNC_COUNT];
  logic [7:0] active_ff [adc_cfg_pkg::FUNC_COUNT];

  // host writes land in the shadow copy only; reads see it too, so a
  // host can check a setting before it commits it
  always_ff @(posedge I_SYS_CLK)
  begin
    if (cfg_rst)
    begin
      for (int i = 0; i < adc_cfg_pkg::FUNC_COUNT; i++)
        shadow_ff[i] <= func_default(adc_cfg_pkg::ADDR_FUNC_FIRST + 13'(i));
    end
    else if (wr_func)
      shadow_ff[func_index(wr_addr_ff)] <= wr_data & func_mask(wr_addr_ff);
  end

  // commit copies the whole shadow set in one cycle, no partial update,
  // so the converter never runs on a half-changed setup
  always_ff @(posedge I_SYS_CLK)
  begin
    if (cfg_rst)
    begin
      for (int i = 0; i < adc_cfg_pkg::FUNC_COUNT; i++)
        active_ff[i] <= func_default(adc_cfg_pkg::ADDR_FUNC_FIRST + 13'(i));
    end
    else if (commit)
    begin
      for (int i = 0; i < adc_cfg_pkg::FUNC_COUNT; i++)
        active_ff[i] <= shadow_ff[i];
    end
  end

  // ----------------------------------------------------------------
  // readback mux
  // ----------------------------------------------------------------
  logic [7:0] port_view;
  // mirrored so the byte reads alike in either bit order
  assign port_view = {1'b0, lsb_first_ff, 1'b0, 2'b11, 1'b0, lsb_first_ff, 1'b0};

  // the mux follows the live address, which the engine samples on the
  // first falling sclk edge of each read byte
  always_comb
  begin
    if (addr == adc_cfg_pkg::ADDR_PORT_SETUP)
      rd_data = port_view;
    else if (addr == adc_cfg_pkg::ADDR_PART_ID)
      rd_data = adc_cfg_pkg::PART_ID_VALUE;
    else if (addr == adc_cfg_pkg::ADDR_SPEED_VARIANT)
      rd_data = {1'b0, adc_cfg_pkg::VARIANT_VALUE, 4'h_0};
    else if (addr == adc_cfg_pkg::ADDR_DEVICE_INDEX)
      rd_data = {2'b00, index_ff};
    else if (is_func(addr))
      rd_data = shadow_ff[func_index(addr)];
    else
      rd_data = 8'h_00; // commit self-clears, unmapped reads zero
  end

  // ----------------------------------------------------------------
  // power, clock and test controls come from the active copy; bit order and index are direct
  // ----------------------------------------------------------------
  // fixed indices, worked out once; a write without commit never shows
  // on the power, clock and test pins
  logic [4:0] idx_pwr;
  logic [4:0] idx_clk;
  logic [4:0] idx_test;
  assign idx_pwr = func_index(adc_cfg_pkg::ADDR_POWER_MODES);
  assign idx_clk = func_index(adc_cfg_pkg::ADDR_CLOCK_COND);
  assign idx_test = func_index(adc_cfg_pkg::ADDR_TEST_IO);
  assign O_LSB_FIRST = lsb_first_ff;
  assign O_DEVICE_INDEX = index_ff;
  assign O_POWER_MODE = active_ff[idx_pwr][2:0];
  assign O_DCS_ENABLE = active_ff[idx_clk][adc_cfg_pkg::CLK_DCS_POS];
  assign O_TEST_IO = active_ff[idx_test];

endmodule

// ==== rtl/adc_cfg_pkg.sv ====
package adc_cfg_pkg;

  // ----------------------------------------------------------------
  // serial frame layout
  // ----------------------------------------------------------------
  localparam int unsigned INSTR_BITS = 16;
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned DATA_W = 8;
  localparam logic [3:0] INSTR_LAST_BIT = 4'h_F;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h_7;
  localparam int unsigned INSTR_RW_POS = 15;
  localparam logic [1:0] LEN_STREAM = 2'h_3;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [12:0] ADDR_PORT_SETUP = 13'h_0000;
  localparam logic [12:0] ADDR_PART_ID = 13'h_0001;
  localparam logic [12:0] ADDR_SPEED_VARIANT = 13'h_0002;
  localparam logic [12:0] ADDR_DEVICE_INDEX = 13'h_0005;
  localparam logic [12:0] ADDR_FUNC_FIRST = 13'h_0008;
  localparam logic [12:0] ADDR_POWER_MODES = 13'h_0008;
  localparam logic [12:0] ADDR_CLOCK_COND = 13'h_0009;
  localparam logic [12:0] ADDR_TEST_IO = 13'h_000D;
  localparam logic [12:0] ADDR_FUNC_LAST = 13'h_0022;
  localparam logic [12:0] ADDR_SHADOW_COMMIT = 13'h_00FF;
  localparam int unsigned FUNC_COUNT = 27;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned PS_LSB_FIRST_HI = 6;
  localparam int unsigned PS_SOFT_RST_HI = 5;
  localparam int unsigned PS_SOFT_RST_LO = 2;
  localparam int unsigned PS_LSB_FIRST_LO = 1;
  localparam int unsigned CLK_DCS_POS = 0;
  localparam int unsigned COMMIT_POS = 0;
  localparam int unsigned VARIANT_LSB = 4;

  // ----------------------------------------------------------------
  // reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PORT_SETUP = 8'h_18;
  localparam logic [7:0] RST_DEVICE_INDEX = 8'h_0F;
  localparam logic [7:0] MASK_DEVICE_INDEX = 8'h_3F;
  localparam logic [7:0] RST_POWER_MODES = 8'h_00;
  localparam logic [7:0] MASK_POWER_MODES = 8'h_07;
  localparam logic [7:0] RST_CLOCK_COND = 8'h_01;
  localparam logic [7:0] MASK_CLOCK_COND = 8'h_01;
  localparam logic [7:0] RST_FUNC_OTHER = 8'h_00;
  localparam logic [7:0] MASK_FUNC_OTHER = 8'h_FF;
  localparam logic [7:0] COMMIT_VALUE = 8'h_01;

  // identity values: arbitrary neutral values
  localparam logic [7:0] PART_ID_VALUE = 8'h_5A;
  localparam logic [2:0] VARIANT_VALUE = 3'h_3;

  // serial engine states, gray along instr -> data
  typedef enum logic [1:0] {
    ST_INSTR = 2'b00,
    ST_DATA = 2'b01
  } port_state_t;

endpackage

// ==== rtl/serial_port_engine.sv ====
module serial_port_engine (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_sclk,
  input wire logic i_csb_n,
  input wire logic i_sdio,
  input wire logic i_lsb_first,
  input wire logic [7:0] i_rd_data,
  output logic o_sdio,
  output logic o_sdio_oe,
  output logic [12:0] o_addr,
  output logic o_wr_stb,
  output logic [7:0] o_wr_data
);

  // ----------------------------------------------------------------
  // sclk edge detection
  // ----------------------------------------------------------------
  // sclk is sampled as a plain synchronous input, so it must run at
  // half of the system clock or slower for every edge to be seen
  logic sclk_ff;
  logic sclk_rise;
  logic sclk_fall;
  logic active;
  assign sclk_rise = i_sclk & ~sclk_ff & ~i_csb_n;
  assign sclk_fall = ~i_sclk & sclk_ff & ~i_csb_n;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      sclk_ff <= 1'b0;
    else
      sclk_ff <= i_sclk;
  end

  // ----------------------------------------------------------------
  // frame state
  // ----------------------------------------------------------------
  adc_cfg_pkg::port_state_t state_ff;
  logic [3:0] cnt_ff;
  logic [15:0] sh_ff;
  logic [15:0] nxt_sh;
  logic rd_ff;
  logic [1:0] len_ff;
  logic [1:0] left_ff;
  logic [12:0] addr_ff;
  logic [7:0] nxt_byte;

  // order of arrival follows the live bit-order setting
  assign nxt_sh = i_lsb_first ? {i_sdio, sh_ff[15:1]} : {sh_ff[14:0], i_sdio};
  assign nxt_byte = i_lsb_first ? nxt_sh[15:8] : nxt_sh[7:0];
  assign active = (state_ff == adc_cfg_pkg::ST_DATA);

  // instruction decode, byte counting and address stepping
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_ff <= adc_cfg_pkg::ST_INSTR;
      cnt_ff <= 4'h_0;
      sh_ff <= 16'h_0000;
      rd_ff <= 1'b0;
      len_ff <= 2'h_0;
      left_ff <= 2'h_0;
      addr_ff <= 13'h_0000;
    end
    else if (i_csb_n)
    begin
      // a partial byte aborts the frame; a stream ends on csb high
      if (cnt_ff != 4'h_0 || len_ff == adc_cfg_pkg::LEN_STREAM)
      begin
        state_ff <= adc_cfg_pkg::ST_INSTR;
        cnt_ff <= 4'h_0;
        len_ff <= 2'h_0;
      end
    end
    else if (sclk_rise)
    begin
      sh_ff <= nxt_sh;
      if (!active)
      begin
        if (cnt_ff == adc_cfg_pkg::INSTR_LAST_BIT)
        begin
          state_ff <= adc_cfg_pkg::ST_DATA;
          rd_ff <= nxt_sh[adc_cfg_pkg::INSTR_RW_POS];
          len_ff <= nxt_sh[14:13];
          left_ff <= nxt_sh[14:13];
          addr_ff <= nxt_sh[12:0];
          cnt_ff <= 4'h_0;
        end
        else
          cnt_ff <= cnt_ff + 4'h_1;
      end
      else if (cnt_ff[2:0] == adc_cfg_pkg::BYTE_LAST_BIT)
      begin
        cnt_ff <= 4'h_0;
        addr_ff <= i_lsb_first ? addr_ff + 13'h_0001 : addr_ff - 13'h_0001;
        if (len_ff != adc_cfg_pkg::LEN_STREAM && left_ff == 2'h_0)
          state_ff <= adc_cfg_pkg::ST_INSTR;
        else if (len_ff != adc_cfg_pkg::LEN_STREAM)
          left_ff <= left_ff - 2'h_1;
      end
      else
        cnt_ff <= cnt_ff + 4'h_1;
    end
  end

  // write strobe on the last rising edge of each write byte
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_wr_stb <= 1'b0;
      o_wr_data <= 8'h_00;
    end
    else
    begin
      o_wr_stb <= sclk_rise & active & ~rd_ff & (cnt_ff[2:0] == adc_cfg_pkg::BYTE_LAST_BIT);
      o_wr_data <= nxt_byte;
    end
  end
  assign o_addr = addr_ff;

  // ----------------------------------------------------------------
  // readback shifter, changes on sclk falling edges
  // ----------------------------------------------------------------
  logic [7:0] tx_ff;
  logic [7:0] tx_src;
  logic sdo_ff;
  assign tx_src = (cnt_ff == 4'h_0) ? i_rd_data : tx_ff;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      tx_ff <= 8'h_00;
      sdo_ff <= 1'b0;
    end
    else if (sclk_fall && active && rd_ff)
    begin
      sdo_ff <= i_lsb_first ? tx_src[0] : tx_src[7];
      tx_ff <= i_lsb_first ? {1'b0, tx_src[7:1]} : {tx_src[6:0], 1'b0};
    end
  end
  assign o_sdio = sdo_ff;
  assign o_sdio_oe = active & rd_ff & ~i_csb_n;

endmodule

// ==== test/adc_cfg_asserts.sv ====
// ------------------------------------------------------------
// port checks for the register map
// ------------------------------------------------------------
module adc_cfg_asserts (
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic I_SCLK,
  input wire logic I_CSB_N,
  input wire logic I_SDIO,
  input wire logic O_SDIO,
  input wire logic O_SDIO_OE,
  input wire logic O_LSB_FIRST,
  input wire logic [5:0] O_DEVICE_INDEX,
  input wire logic [2:0] O_POWER_MODE,
  input wire logic O_DCS_ENABLE,
  input wire logic [7:0] O_TEST_IO
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (I_RST);

  // a write lands two or three clocks after the rise that ends its byte
  sequence s_landed;
    $past(I_SCLK, 2) || $past(I_SCLK, 3);
  endsequence
  // read bits move one clock after a sampled sclk fall
  sequence s_fell_before;
    !$past(I_SCLK) && $past(I_SCLK, 2);
  endsequence

  property p_rst_dcs;
    $fell(I_RST) |-> O_DCS_ENABLE;
  endproperty
  a_rst_dcs: assert property (p_rst_dcs) else $error("stabilizer off after reset");
  property p_rst_regs;
    $fell(I_RST) |-> O_DEVICE_INDEX == 6'h_0F && O_POWER_MODE == 3'h_0 && O_TEST_IO == 8'h_00;
  endproperty
  a_rst_regs: assert property (p_rst_regs) else $error("bad defaults after reset");
  property p_rst_order;
    $fell(I_RST) |-> !O_LSB_FIRST && !O_SDIO_OE;
  endproperty
  a_rst_order: assert property (p_rst_order) else $error("not msb first after reset");
  property p_oe_idle;
    I_CSB_N && $past(I_CSB_N) |-> !O_SDIO_OE;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("sdio driven while deselected");
  property p_rd_shift;
    O_SDIO_OE && $past(O_SDIO_OE) && $changed(O_SDIO) |-> s_fell_before;
  endproperty
  a_rd_shift: assert property (p_rd_shift) else $error("read bit moved off a fall");
  property p_idx_time;
    $changed(O_DEVICE_INDEX) && !$past(I_RST) |-> s_landed;
  endproperty
  a_idx_time: assert property (p_idx_time) else $error("index moved without a write");
  property p_func_time;
    $changed({O_POWER_MODE, O_DCS_ENABLE, O_TEST_IO}) && !$past(I_RST) |-> s_landed;
  endproperty
  a_func_time: assert property (p_func_time) else $error("active reg moved off a write");
  property p_order_time;
    $changed(O_LSB_FIRST) && !$past(I_RST) |-> s_landed;
  endproperty
  a_order_time: assert property (p_order_time) else $error("bit order moved off a write");
endmodule

bind adc_config_register_map adc_cfg_asserts u_adc_cfg_asserts (
  .I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST), .I_SCLK(I_SCLK), .I_CSB_N(I_CSB_N),
  .I_SDIO(I_SDIO), .O_SDIO(O_SDIO), .O_SDIO_OE(O_SDIO_OE), .O_LSB_FIRST(O_LSB_FIRST),
  .O_DEVICE_INDEX(O_DEVICE_INDEX), .O_POWER_MODE(O_POWER_MODE),
  .O_DCS_ENABLE(O_DCS_ENABLE), .O_TEST_IO(O_TEST_IO)
);

// ==== test/serial_host.sv ====
// ------------------------------------------------------------
// serial control-port host
// ------------------------------------------------------------
module serial_host (
  input wire logic i_clk,
  input wire logic i_sdio,
  output logic o_sclk,
  output logic o_csb_n,
  output logic o_sdio,
  output logic o_sdio_oe
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle: deselected, clock parked low
  initial
  begin
    o_sclk = 1'b0;
    o_csb_n = 1'b1;
    o_sdio = 1'b0;
    o_sdio_oe = 1'b1;
  end

  // one frame, one byte; ph below 2 would race the device's read bit
  task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd,
    input logic lsb, input int ph, input int cut, output logic [7:0] q);
    logic [23:0] w;
    int k;
    w = {rd, 2'b00, a, wd};
    q = 8'h_00;
    @(posedge i_clk);
    o_csb_n <= 1'b0;
    repeat (ph) @(posedge i_clk);
    for (int i = 0; i < cut; i++)
    begin
      k = lsb ? ((i < 16) ? i + 8 : i - 16) : 23 - i;
      o_sclk <= 1'b0;
      o_sdio <= w[k];
      o_sdio_oe <= !(rd && i > 15);
      repeat (ph) @(posedge i_clk);
      o_sclk <= 1'b1;
      if (i > 15)
        q[k] = i_sdio;
      repeat (ph) @(posedge i_clk);
    end
    o_sclk <= 1'b0;
    repeat (ph) @(posedge i_clk);
    o_csb_n <= 1'b1;
    o_sdio_oe <= 1'b1;
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
  endtask

  // two-byte write; the second byte goes one address down in msb-first
  // order and one address up in lsb-first order
  task automatic xfer_pair(input logic [12:0] a, input logic [7:0] d0, input logic [7:0] d1,
    input logic lsb, input int ph);
    logic [31:0] w;
    int k;
    w = {1'b0, 2'b01, a, d0, d1};
    @(posedge i_clk);
    o_csb_n <= 1'b0;
    repeat (ph) @(posedge i_clk);
    for (int i = 0; i < 32; i++)
    begin
      k = lsb ? ((i < 16) ? i + 16 : ((i < 24) ? i - 8 : i - 24)) : 31 - i;
      o_sclk <= 1'b0;
      o_sdio <= w[k];
      repeat (ph) @(posedge i_clk);
      o_sclk <= 1'b1;
      repeat (ph) @(posedge i_clk);
    end
    o_sclk <= 1'b0;
    repeat (ph) @(posedge i_clk);
    o_csb_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
  endtask

  // writes the commit value to 0xFF, copying shadow to active
  task automatic commit(input logic lsb);
    logic [7:0] q;
    xfer(1'b0, adc_cfg_pkg::ADDR_SHADOW_COMMIT, adc_cfg_pkg::COMMIT_VALUE, lsb, 3, 24, q);
  endtask
endmodule

// ==== test/adc_config_register_map_test.sv ====
module adc_config_register_map_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, sclk, csb_n, h_d, h_oe, sdio_o, sdio_oe, lsb_first, dcs, lsb_mode;
  logic [5:0] dev_idx;
  logic [2:0] pwr;
  logic [7:0] test_io, seed, v, e_tio;
  logic [2:0] e_pm;
  wire logic sdio_line;
  int ph, n_mismatch, samples_checked;

  // a released line shows the inverse of the last driven bit
  assign sdio_line = sdio_oe ? sdio_o : (h_oe ? h_d : ~h_d);

  adc_config_register_map u_adc_config_register_map (
    .I_SYS_CLK(clk), .I_RST(rst), .I_SCLK(sclk), .I_CSB_N(csb_n), .I_SDIO(sdio_line),
    .O_SDIO(sdio_o), .O_SDIO_OE(sdio_oe), .O_LSB_FIRST(lsb_first),
    .O_DEVICE_INDEX(dev_idx), .O_POWER_MODE(pwr), .O_DCS_ENABLE(dcs), .O_TEST_IO(test_io)
  );
  serial_host u_serial_host (
    .i_clk(clk), .i_sdio(sdio_line), .o_sclk(sclk), .o_csb_n(csb_n), .o_sdio(h_d),
    .o_sdio_oe(h_oe)
  );

  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] next_rand(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // undefined bits are dropped on store
  function automatic logic [7:0] stored(input logic [12:0] a, input logic [7:0] d);
    case (a)
      adc_cfg_pkg::ADDR_POWER_MODES: return d & adc_cfg_pkg::MASK_POWER_MODES;
      adc_cfg_pkg::ADDR_CLOCK_COND: return d & adc_cfg_pkg::MASK_CLOCK_COND;
      adc_cfg_pkg::ADDR_DEVICE_INDEX: return d & adc_cfg_pkg::MASK_DEVICE_INDEX;
      adc_cfg_pkg::ADDR_TEST_IO: return d;
      default: return 8'h_00;
    endcase
  endfunction

  task automatic check_pin(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t pin %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_rd(input logic [12:0] a, input logic [7:0] exp, input logic [7:0] m);
    logic [7:0] q;
    u_serial_host.xfer(1'b1, a, 8'h_00, lsb_mode, ph, 24, q);
    samples_checked++;
    if ((q & m) !== (exp & m))
    begin
      n_mismatch++;
      $display("ERROR t=%0t read %h at %h expected %h", $time, q, a, exp);
    end
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_serial_host.xfer(1'b0, a, d, lsb_mode, ph, 24, q);
  endtask

  task automatic check_defaults;
    check_pin({7'h_00, dcs}, 8'h_01);
    check_pin({2'b00, dev_idx}, adc_cfg_pkg::RST_DEVICE_INDEX);
    check_pin({5'h_00, pwr}, adc_cfg_pkg::RST_POWER_MODES);
    check_pin(test_io, 8'h_00);
    check_pin({7'h_00, lsb_first}, 8'h_00);
  endtask

  task automatic done(input string name);
    $display("test %s finished, mismatches so far %0d", name, n_mismatch);
  endtask

  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // watchdog, far beyond the longest expected run
  initial
  begin
    #2_000_000;
    n_mismatch++;
    tally_and_finish();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    seed = 8'h_2C;
    ph = 3;
    lsb_mode = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check_defaults();
    check_rd(adc_cfg_pkg::ADDR_PORT_SETUP, 8'h_18, 8'h_FF);
    check_rd(adc_cfg_pkg::ADDR_CLOCK_COND, 8'h_01, 8'h_FF);
    wr(adc_cfg_pkg::ADDR_PART_ID, ~adc_cfg_pkg::PART_ID_VALUE);
    check_rd(adc_cfg_pkg::ADDR_PART_ID, adc_cfg_pkg::PART_ID_VALUE, 8'h_FF);
    check_rd(adc_cfg_pkg::ADDR_SPEED_VARIANT, 8'h_30, 8'h_70);
    wr(13'h_0003, 8'h_00);
    check_rd(13'h_0003, 8'h_00, 8'h_FF);
    done("identity");
    e_pm = 3'h_0;
    e_tio = 8'h_00;
    // random contents, slow and prompt host alike
    for (int n = 0; n < 6; n++)
    begin
      seed = next_rand(seed);
      v = seed;
      ph = v[0] ? 5 : 3;
      wr(adc_cfg_pkg::ADDR_POWER_MODES, v);
      wr(adc_cfg_pkg::ADDR_TEST_IO, ~v);
      wr(adc_cfg_pkg::ADDR_DEVICE_INDEX, v);
      check_pin({2'b00, dev_idx}, stored(adc_cfg_pkg::ADDR_DEVICE_INDEX, v));
      wr(adc_cfg_pkg::ADDR_SHADOW_COMMIT, 8'h_02);
      check_pin({5'h_00, pwr}, {5'h_00, e_pm});
      check_pin(test_io, e_tio);
      check_rd(adc_cfg_pkg::ADDR_POWER_MODES, stored(adc_cfg_pkg::ADDR_POWER_MODES, v),
        8'h_FF);
      u_serial_host.commit(lsb_mode);
      e_pm = v[2:0];
      e_tio = ~v;
      check_pin({5'h_00, pwr}, stored(adc_cfg_pkg::ADDR_POWER_MODES, v));
      check_pin(test_io, e_tio);
    end
    ph = 3;
    done("random");
    wr(adc_cfg_pkg::ADDR_CLOCK_COND, 8'h_00);
    check_pin({7'h_00, dcs}, 8'h_01);
    u_serial_host.commit(lsb_mode);
    check_pin({7'h_00, dcs}, 8'h_00);
    // two-byte frames: msb first walks the address down
    u_serial_host.xfer_pair(adc_cfg_pkg::ADDR_TEST_IO, 8'h_A5, 8'h_3C, lsb_mode, ph);
    check_rd(adc_cfg_pkg::ADDR_TEST_IO, 8'h_A5, 8'h_FF);
    check_rd(13'h_000C, 8'h_3C, 8'h_FF);
    wr(adc_cfg_pkg::ADDR_PORT_SETUP, 8'h_5A);
    check_pin({7'h_00, lsb_first}, 8'h_01);
    lsb_mode = 1'b1;
    check_rd(adc_cfg_pkg::ADDR_PORT_SETUP, 8'h_5A, 8'h_FF);
    // lsb first walks the address up; the clock byte keeps only its enable
    u_serial_host.xfer_pair(adc_cfg_pkg::ADDR_POWER_MODES, 8'h_06, 8'h_FE, lsb_mode, ph);
    check_rd(adc_cfg_pkg::ADDR_POWER_MODES, 8'h_06, 8'h_FF);
    check_rd(adc_cfg_pkg::ADDR_CLOCK_COND, 8'h_00, 8'h_FF);
    wr(adc_cfg_pkg::ADDR_PORT_SETUP, 8'h_3C);
    lsb_mode = 1'b0;
    check_defaults();
    check_rd(adc_cfg_pkg::ADDR_CLOCK_COND, 8'h_01, 8'h_FF);
    done("bit order and soft reset");
    wr(adc_cfg_pkg::ADDR_TEST_IO, 8'h_C3);
    u_serial_host.commit(lsb_mode);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check_defaults();
    u_serial_host.xfer(1'b0, adc_cfg_pkg::ADDR_TEST_IO, 8'h_AA, 1'b0, 3, 20, v);
    check_rd(adc_cfg_pkg::ADDR_TEST_IO, 8'h_00, 8'h_FF);
    done("hard reset and abort");
    tally_and_finish();
  end
endmodule
